// ### shared/temp_limit_pkg.sv
`default_nettype none
package temp_limit_pkg;
    localparam int NUM_CH = 4;
    localparam logic [7:0] ADDR_UNDER_STATUS = 8'h36;
    localparam logic [7:0] ADDR_CRIT_STATUS = 8'h37;
    localparam logic [7:0] ADDR_AVG_CTRL = 8'h40;
    localparam logic [7:0] ADDR_PART_ID = 8'hfd;
    localparam logic [7:0] ADDR_MAKER_ID = 8'hfe;
    localparam logic [7:0] ADDR_DIE_REV = 8'hff;
    localparam logic [7:0] RESET_STATUS = 8'h00;
    localparam logic [7:0] RESET_AVG_CTRL = 8'h00;
    localparam int AVG_FIELD_LSB = 0;
    localparam int AVG_FIELD_W = 2;
    // Consecutive count encodings and the counts they decode to
    localparam logic [2:0] CONSEC_ONE = 3'h0;
    localparam logic [2:0] CONSEC_TWO = 3'h1;
    localparam logic [2:0] CONSEC_THREE = 3'h3;
    localparam logic [2:0] CONSEC_FOUR = 3'h7;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_TWO = 3'h2;
    localparam logic [2:0] CNT_THREE = 3'h3;
    localparam logic [2:0] CNT_FOUR = 3'h4;

    typedef enum logic [1:0] {
        AVG_OFF = 2'b00,
        AVG_LEVEL1 = 2'b01,
        AVG_LEVEL2 = 2'b10
    } avg_level_e;

    // One measurement result from the conversion engine
    typedef struct packed {
        logic valid;
        logic [3:0] under;
        logic [3:0] over_crit;
        logic [3:0] below_crit_hyst;
    } meas_s;

    // Register access from the serial bus engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage
`default_nettype wire

// ### hw/temp_limit_status_filter_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Set per-channel under flag below low limit
// - Any under flag sets under summary bit
// - Reading under status clears flags and summary in latched mode
// - Alarm needs flag set and count reached
// - Flags latch, or follow live in comparator
// - Set per-channel critical flag above limit
// - Any critical flag sets critical summary
// - Reading critical status clears nothing
// - Critical flag clears below limit minus hysteresis
// - Critical summary clears when all clear
// - Any critical flag drives critical pin
// - Two-bit averaging field, external one only
// - Decode 00 off, 01/10 level1, 11 level2
// - Read-only part identifier register
// - Read-only maker identifier register
// - Read-only die revision register
// - Count field decodes one to four
module temp_limit_status_filter_regs #(
    parameter logic [7:0] PART_ID = 8'h11, // Arbitrary value
    parameter logic [7:0] MAKER_ID = 8'h22, // Arbitrary value
    parameter logic [7:0] DIE_REV = 8'h01 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register access
    input wire temp_limit_pkg::reg_req_s req_i,
    output logic [7:0] rdata_o,
    // Measurement results
    input wire temp_limit_pkg::meas_s meas_i,
    // Alarm configuration
    input wire logic comparator_mode_i,
    input wire logic [2:0] alarm_consecutive_count_i,
    // Status summary bits
    output logic under_summary_o,
    output logic crit_summary_o,
    // Averaging selection for external channel one
    output temp_limit_pkg::avg_level_e ext1_avg_level_o,
    // Pins
    output logic alarm_output_pin_o,
    output logic crit_pin_o
);

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0] under_flags;
    logic [3:0] crit_flags;
    logic [1:0] avg_field;
    logic [2:0] consec_cnt;
    logic [2:0] needed_cnt;
    logic rd_under;
    logic wr_avg;
    logic any_under_now;

    assign rd_under = req_i.rd && (req_i.addr == temp_limit_pkg::ADDR_UNDER_STATUS);
    assign wr_avg = req_i.wr && (req_i.addr == temp_limit_pkg::ADDR_AVG_CTRL);
    assign any_under_now = meas_i.valid && (|meas_i.under);

    ////////////////////////////////////////////////////////////////////
    // Under-range flags
    // set, clear, comparator
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            under_flags <= temp_limit_pkg::RESET_STATUS[3:0];
        end else if (comparator_mode_i) begin
            if (meas_i.valid) begin
                under_flags <= meas_i.under;
            end
        end else begin
            under_flags <= (rd_under ? 4'h0 : under_flags) | (meas_i.valid ? meas_i.under : 4'h0);
        end
    end

    // Critical flags
    // set, hysteresis clear
    generate
        for (genvar ch = 0; ch < temp_limit_pkg::NUM_CH; ch++) begin : g_crit
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    crit_flags[ch] <= 1'b0;
                end else if (meas_i.valid && meas_i.over_crit[ch]) begin
                    crit_flags[ch] <= 1'b1;
                end else if (meas_i.valid && meas_i.below_crit_hyst[ch]) begin
                    crit_flags[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Summary bits and pins
    // summaries follow flags
    assign under_summary_o = |under_flags;
    assign crit_summary_o = |crit_flags;
    assign crit_pin_o = |crit_flags;

    // Consecutive count target
    // count decode
    always_comb begin
        case (alarm_consecutive_count_i)
            temp_limit_pkg::CONSEC_ONE: needed_cnt = temp_limit_pkg::CNT_ONE;
            temp_limit_pkg::CONSEC_TWO: needed_cnt = temp_limit_pkg::CNT_TWO;
            temp_limit_pkg::CONSEC_THREE: needed_cnt = temp_limit_pkg::CNT_THREE;
            temp_limit_pkg::CONSEC_FOUR: needed_cnt = temp_limit_pkg::CNT_FOUR;
            default: needed_cnt = temp_limit_pkg::CNT_ONE;
        endcase
    end

    // Consecutive out-of-limit measurement counter, saturating
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            consec_cnt <= 3'h0;
        end else if (meas_i.valid) begin
            if (!any_under_now) begin
                consec_cnt <= 3'h0;
            end else if (consec_cnt < temp_limit_pkg::CNT_FOUR) begin
                consec_cnt <= consec_cnt + 3'h1;
            end
        end
    end

    // Alarm pin
    // gated by flags and count
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_output_pin_o <= 1'b0;
        end else begin
            alarm_output_pin_o <= (|under_flags) && (consec_cnt >= needed_cnt);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Averaging control
    // low field writable only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avg_field <= temp_limit_pkg::RESET_AVG_CTRL[1:0];
        end else if (wr_avg) begin
            avg_field <= req_i.wdata[temp_limit_pkg::AVG_FIELD_LSB +: temp_limit_pkg::AVG_FIELD_W];
        end
    end

    always_comb begin
        case (avg_field)
            2'b00: ext1_avg_level_o = temp_limit_pkg::AVG_OFF;
            2'b01: ext1_avg_level_o = temp_limit_pkg::AVG_LEVEL1;
            2'b10: ext1_avg_level_o = temp_limit_pkg::AVG_LEVEL1;
            default: ext1_avg_level_o = temp_limit_pkg::AVG_LEVEL2;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, registered on the read strobe
    // identifiers and zero fill
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            case (req_i.addr)
                temp_limit_pkg::ADDR_UNDER_STATUS: rdata_o <= {4'h0, under_flags};
                temp_limit_pkg::ADDR_CRIT_STATUS: rdata_o <= {4'h0, crit_flags};
                temp_limit_pkg::ADDR_AVG_CTRL: rdata_o <= {6'h00, avg_field};
                temp_limit_pkg::ADDR_PART_ID: rdata_o <= PART_ID;
                temp_limit_pkg::ADDR_MAKER_ID: rdata_o <= MAKER_ID;
                temp_limit_pkg::ADDR_DIE_REV: rdata_o <= DIE_REV;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    a_under_clear_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (rd_under && !comparator_mode_i && !meas_i.valid) |=> (under_flags == 4'h0))
        else $error("under flags not cleared by read");
    a_under_set_wins: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (rd_under && !comparator_mode_i && meas_i.valid) |=> (under_flags == $past(meas_i.under)))
        else $error("new under flag lost on read");
    a_under_latch: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (!rd_under && !comparator_mode_i) |=> ((under_flags & $past(under_flags)) == $past(under_flags)))
        else $error("under flag dropped without read");
    a_crit_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (meas_i.valid && meas_i.over_crit[0]) |=> crit_flags[0])
        else $error("critical flag not set");
    a_crit_read_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == temp_limit_pkg::ADDR_CRIT_STATUS && !meas_i.valid) |=> $stable(crit_flags))
        else $error("critical read changed flags");
    a_crit_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
        crit_pin_o == (crit_flags != 4'h0))
        else $error("critical pin mismatch");
    a_alarm_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
        alarm_output_pin_o |-> $past(under_flags != 4'h0))
        else $error("alarm without flag");
    a_avg_decode: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (avg_field == 2'b10) |-> (ext1_avg_level_o == temp_limit_pkg::AVG_LEVEL1))
        else $error("averaging decode wrong");
    a_id_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == temp_limit_pkg::ADDR_PART_ID) |=> (rdata_o == PART_ID))
        else $error("part id read wrong");
    c_under_read: cover property (@(posedge clk_i) disable iff (!nrst_i) under_summary_o ##1 rd_under);
    c_alarm_four: cover property (@(posedge clk_i) disable iff (!nrst_i)
        (alarm_consecutive_count_i == temp_limit_pkg::CONSEC_FOUR) && alarm_output_pin_o);
    c_crit_clear: cover property (@(posedge clk_i) disable iff (!nrst_i) crit_summary_o ##1 !crit_summary_o);
    // Comparator mode tracking the live condition
    c_comp_follow: cover property (@(posedge clk_i) disable iff (!nrst_i)
        comparator_mode_i && under_summary_o ##1 !under_summary_o);
    // Heaviest averaging selected
    c_avg_level2: cover property (@(posedge clk_i) disable iff (!nrst_i)
        ext1_avg_level_o == temp_limit_pkg::AVG_LEVEL2);

    ////////////////////////////////////////////////////////////////////
    // Summary bits raised by a new flag
    a_under_summary: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (meas_i.valid && (meas_i.under != 4'h0)) |=> under_summary_o)
        else $error("under summary not raised");
    a_crit_summary: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (meas_i.valid && (meas_i.over_crit != 4'h0)) |=> crit_summary_o)
        else $error("critical summary not raised");
    // Critical summary drops only with the last flag
    a_crit_summary_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(crit_summary_o) |-> (crit_flags == 4'h0) && ($past(crit_flags) != 4'h0))
        else $error("critical summary dropped early");

    // Comparator mode: a read leaves the live flags alone
    a_comp_no_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (rd_under && comparator_mode_i && !meas_i.valid) |=> $stable(under_flags))
        else $error("comparator read cleared flags");

    ////////////////////////////////////////////////////////////////////
    // Alarm timing against the count setting
    // Setting one: a single out-of-limit result raises the pin two edges later
    a_alarm_single: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ((alarm_consecutive_count_i == temp_limit_pkg::CONSEC_ONE) && meas_i.valid && (meas_i.under != 4'h0))
        ##1 (alarm_consecutive_count_i == temp_limit_pkg::CONSEC_ONE) |=> alarm_output_pin_o)
        else $error("alarm late for single count");
    // Setting four: the pin needs four results in a row
    a_alarm_four: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (alarm_output_pin_o && ($past(alarm_consecutive_count_i) == temp_limit_pkg::CONSEC_FOUR))
        |-> ($past(consec_cnt) == temp_limit_pkg::CNT_FOUR))
        else $error("alarm before fourth result");
    // No flag, no alarm, whatever the count
    a_alarm_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (under_flags == 4'h0) |=> !alarm_output_pin_o)
        else $error("alarm with no flag");

    ////////////////////////////////////////////////////////////////////
    // Consecutive counter: a clean result restarts the run
    a_count_restart: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (meas_i.valid && (meas_i.under == 4'h0)) |=> (consec_cnt == 3'h0))
        else $error("count not restarted");
    // The count never climbs past four
    a_count_ceiling: assert property (@(posedge clk_i) disable iff (!nrst_i)
        consec_cnt <= temp_limit_pkg::CNT_FOUR)
        else $error("count above four");

    ////////////////////////////////////////////////////////////////////
    // Averaging field write and hold
    a_avg_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_avg |=> (avg_field == $past(req_i.wdata[temp_limit_pkg::AVG_FIELD_LSB +: temp_limit_pkg::AVG_FIELD_W])))
        else $error("averaging field not written");
    a_avg_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !wr_avg |=> $stable(avg_field))
        else $error("averaging field changed without write");
    // Full decode of the two-bit field
    a_avg_decode_all: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ext1_avg_level_o == ((avg_field == 2'h0) ? temp_limit_pkg::AVG_OFF :
        (avg_field == 2'h3) ? temp_limit_pkg::AVG_LEVEL2 : temp_limit_pkg::AVG_LEVEL1))
        else $error("averaging decode mismatch");

    ////////////////////////////////////////////////////////////////////
    // Identifier reads and zero fill
    a_maker_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == temp_limit_pkg::ADDR_MAKER_ID) |=> (rdata_o == MAKER_ID))
        else $error("maker id read wrong");
    a_rev_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == temp_limit_pkg::ADDR_DIE_REV) |=> (rdata_o == DIE_REV))
        else $error("die revision read wrong");
    // Status and control reads keep their unused bits at zero
    a_status_upper: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && (req_i.addr == temp_limit_pkg::ADDR_UNDER_STATUS ||
        req_i.addr == temp_limit_pkg::ADDR_CRIT_STATUS)) |=> (rdata_o[7:4] == 4'h0))
        else $error("status upper bits not zero");
    a_ctrl_upper: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == temp_limit_pkg::ADDR_AVG_CTRL) |=> (rdata_o[7:2] == 6'h00))
        else $error("control upper bits not zero");
    // A clearing read still returns the flags seen before the clear
    a_under_read_data: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_under |=> (rdata_o[3:0] == $past(under_flags)))
        else $error("under read data wrong");
    // Read data stands until the next read
    a_rdata_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without read");

    ////////////////////////////////////////////////////////////////////
    // Per-channel checks, one copy for each flag bit
    // Each bit is watched alone so a stuck or swapped channel shows up
    // even while another channel holds the summary high
    generate
        for (genvar ch = 0; ch < temp_limit_pkg::NUM_CH; ch++) begin : g_chan_chk
            // A measurement below the low limit sets its bit in either mode
            a_under_set_ch: assert property (@(posedge clk_i) disable iff (!nrst_i)
                (meas_i.valid && meas_i.under[ch]) |=> under_flags[ch])
                else $error("under flag not set");
            // Comparator mode copies the live bit
            a_under_live_ch: assert property (@(posedge clk_i) disable iff (!nrst_i)
                (comparator_mode_i && meas_i.valid) |=> (under_flags[ch] == $past(meas_i.under[ch])))
                else $error("under flag not following live bit");
            // Above the critical limit sets the bit, even with hysteresis seen
            a_crit_set_ch: assert property (@(posedge clk_i) disable iff (!nrst_i)
                (meas_i.valid && meas_i.over_crit[ch]) |=> crit_flags[ch])
                else $error("critical flag not set");
            // Below limit minus hysteresis clears the bit
            a_crit_clear_ch: assert property (@(posedge clk_i) disable iff (!nrst_i)
                (meas_i.valid && !meas_i.over_crit[ch] && meas_i.below_crit_hyst[ch]) |=> !crit_flags[ch])
                else $error("critical flag not cleared by hysteresis");
            // Without a measurement the bit stays put, reads included
            a_crit_hold_ch: assert property (@(posedge clk_i) disable iff (!nrst_i)
                !meas_i.valid |=> $stable(crit_flags[ch]))
                else $error("critical flag changed without measurement");
            // Any set bit drives the critical pin
            a_crit_pin_ch: assert property (@(posedge clk_i) disable iff (!nrst_i)
                crit_flags[ch] |-> crit_pin_o)
                else $error("critical pin not driven");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Elaboration guard: flag vectors and the status fields of the read data are four bits wide
    if (temp_limit_pkg::NUM_CH != 4) begin : g_bad_ch_count
        $error("channel count must be four");
    end
endmodule

`default_nettype wire

// ### dv/smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    // Clock
    input wire logic clk_i,
    // Register requests
    output var temp_limit_pkg::reg_req_s req_o
);
    ////////////////////////////////////////
    // Idle until asked, address and data lines garbled when released
    initial req_o = '0;
    // One-cycle access pulse, then release
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk_i);
        req_o <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk_i);
        req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    endtask
endmodule
`default_nettype wire

// ### dv/temp_limit_status_filter_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module temp_limit_status_filter_regs_bench;
    logic clk_i, nrst_i, comp_i, under_o, crit_o, alarm_o, pin_o;
    logic [2:0] cnt_i;
    logic [7:0] rdata_o, r;
    logic [31:0] seed = 32'h0001_76df;
    int errors = 0;
    int checked = 0;
    logic [7:0] expq[$];
    temp_limit_pkg::reg_req_s req_i;
    temp_limit_pkg::meas_s meas_i;
    temp_limit_pkg::avg_level_e avg_o;
    ////////////////////////////////////////
    // Host model and device under test
    smbus_host_model smbus_host_model_i (.clk_i(clk_i), .req_o(req_i));
    temp_limit_status_filter_regs #(.PART_ID(8'h3a), .MAKER_ID(8'h4b), .DIE_REV(8'h06))
        temp_limit_status_filter_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .rdata_o(rdata_o),
        .meas_i(meas_i), .comparator_mode_i(comp_i), .alarm_consecutive_count_i(cnt_i),
        .under_summary_o(under_o), .crit_summary_o(crit_o), .ext1_avg_level_o(avg_o),
        .alarm_output_pin_o(alarm_o), .crit_pin_o(pin_o));
    ////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        expq.push_back(exp);
        smbus_host_model_i.access(1'b0, addr, 8'h00);
    endtask
    task automatic meas(input logic [3:0] u, input logic [3:0] o, input logic [3:0] h);
        @(posedge clk_i);
        meas_i <= '{valid: 1'b1, under: u, over_crit: o, below_crit_hyst: h};
        @(posedge clk_i);
        meas_i <= '{valid: 1'b0, under: ~u, over_crit: ~o, below_crit_hyst: ~h};
        #1;
    endtask
    ////////////////////////////////////////
    // Read data watcher, 1 ns after the edge that takes each read
    always @(posedge clk_i) begin
        if (req_i.rd === 1'b1) begin
            #1;
            chk(rdata_o, expq.pop_front());
        end
    end
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        errors++;
        finish_test();
    end
    ////////////////////////////////////////
    // Main sequence
    initial begin
        nrst_i = 1'b0;
        comp_i = 1'b0;
        cnt_i = 3'h0;
        meas_i = '0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(8'h36, 8'h00);
        rd(8'h37, 8'h00);
        rd(8'hfd, 8'h3a);
        rd(8'hfe, 8'h4b);
        rd(8'hff, 8'h06);
        rd(8'h50, 8'h00);
        smbus_host_model_i.access(1'b1, 8'hfd, 8'hff);
        rd(8'hfd, 8'h3a);
        rd(8'h40, 8'h00);
        // Every averaging code, random upper bits
        for (int i = 0; i < 4; i++) begin
            r = 8'(rnd());
            r[1:0] = 2'(i);
            smbus_host_model_i.access(1'b1, 8'h40, r);
            rd(8'h40, r & 8'h03);
            chk({6'h00, avg_o}, (i == 0) ? 8'h00 : (i == 3) ? 8'h02 : 8'h01);
        end
        // Latched under flags, clearing read
        r = {4'h0, 4'(rnd()) | 4'h1};
        meas(r[3:0], 4'h0, 4'h0);
        chk({7'h00, under_o}, 8'h01);
        rd(8'h36, r);
        rd(8'h36, 8'h00);
        chk({7'h00, under_o}, 8'h00);
        fork
            rd(8'h36, 8'h00);
            meas(4'h8, 4'h0, 4'h0);
        join
        rd(8'h36, 8'h08);
        // Alarm after each consecutive count setting
        for (int n = 1; n <= 4; n++) begin
            cnt_i <= (n == 1) ? 3'h0 : (n == 2) ? 3'h1 : (n == 3) ? 3'h3 : 3'h7;
            meas(4'h0, 4'h0, 4'h0);
            for (int k = 1; k <= n; k++) begin
                meas(4'h2, 4'h0, 4'h0);
                repeat (2) @(posedge clk_i);
                #1;
                chk({7'h00, alarm_o}, {7'h00, k == n});
            end
            rd(8'h36, 8'h02);
        end
        // Unlisted count code acts as one
        cnt_i <= 3'h2;
        meas(4'h0, 4'h0, 4'h0);
        meas(4'h2, 4'h0, 4'h0);
        repeat (2) @(posedge clk_i);
        #1;
        chk({7'h00, alarm_o}, 8'h01);
        rd(8'h36, 8'h02);
        // Critical flags, no clear on read, hysteresis clear
        meas(4'h0, 4'h5, 4'h0);
        chk({6'h00, pin_o, crit_o}, 8'h03);
        rd(8'h37, 8'h05);
        rd(8'h37, 8'h05);
        meas(4'h0, 4'h0, 4'h1);
        rd(8'h37, 8'h04);
        chk({6'h00, pin_o, crit_o}, 8'h03);
        meas(4'h0, 4'h0, 4'h4);
        chk({6'h00, pin_o, crit_o}, 8'h00);
        // Comparator mode follows live condition
        comp_i <= 1'b1;
        meas(4'h1, 4'h0, 4'h0);
        rd(8'h36, 8'h01);
        rd(8'h36, 8'h01);
        meas(4'h0, 4'h0, 4'h0);
        chk({7'h00, under_o}, 8'h00);
        // Mid-run reset returns everything to its reset value
        meas(4'h1, 4'h2, 4'h0);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        comp_i <= 1'b0;
        #1;
        chk({5'h00, alarm_o, pin_o, under_o}, 8'h00);
        rd(8'h37, 8'h00);
        rd(8'h40, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
